// ### verilog/dpa_defines.svh
`ifndef DPA_DEFINES_SVH
`define DPA_DEFINES_SVH

// register map, byte addresses on the local port
`define DPA_ADDR_CTRL      8'h00
`define DPA_ADDR_FREQ      8'h04
`define DPA_ADDR_STATUS    8'h08
`define DPA_ADDR_MASK      8'h0C
// per-output blocks: addr[7:5] selects the output, addr[4:0] the register
`define DPA_CH_A_SEL       3'h1
`define DPA_CH_B_SEL       3'h2
`define DPA_OFS_FUNC       5'h00
`define DPA_OFS_MIN        5'h04
`define DPA_OFS_MAX        5'h08
`define DPA_OFS_SERIAL     5'h0C
`define DPA_OFS_CURVE      5'h10
`define DPA_OFS_DUTY       5'h14

// function codes
`define DPA_FN_UNUSED      16'h0000
`define DPA_FN_PLC         16'h0101
`define DPA_FN_SERIAL      16'h0102
`define DPA_FN_ECHO_FIRST  16'h3001

// control and status fields
`define DPA_CTRL_PWM_A     0
`define DPA_CTRL_PWM_B     1
`define DPA_ST_PLC_A       0
`define DPA_ST_PLC_B       1
`define DPA_ST_CLIP_A      2
`define DPA_ST_CLIP_B      3
`define DPA_ST_W           4

// command scale: 0.1 % units, 1000 is full scale
`define DPA_PCT_FULL       16'h03E8
`define DPA_PCT_RST_MAX    16'h03E8
`define DPA_PCT_RST_MIN    16'h0000
// 1/1000 as 1049 / 2^20
`define DPA_RECIP_1000     11'h419
`define DPA_RECIP_SHIFT    20

// frequency in Hz
`define DPA_FREQ_MIN       12'h001
`define DPA_FREQ_MAX       12'h9C4
`define DPA_FREQ_RST       12'h1F4
// phase step per Hz at 100 MHz: 2^32 / 1e8 * 1024 = 43980
`define DPA_STEP_PER_HZ    16'hABCC
`define DPA_STEP_SHIFT     10
// phase span per 0.1 %: 2^32 / 1000
`define DPA_THR_PER_STEP   32'h0041_8937

// curve reset: gain 1.0 in 8.8 fixed point, no offset
`define DPA_GAIN_RST       16'h0100
`define DPA_GAIN_SHIFT     8

`endif

// ### verilog/dpa_pkg.sv
`include "dpa_defines.svh"

package dpa_pkg;

    typedef logic [15:0] dpa_pct_type;

    typedef enum logic [2:0] {
        DPA_SRC_NONE     = 3'h0,
        DPA_SRC_INTERNAL = 3'h1,
        DPA_SRC_PLC      = 3'h2,
        DPA_SRC_SERIAL   = 3'h3,
        DPA_SRC_ECHO     = 3'h4
    } dpa_src_type;

    function automatic dpa_src_type dpa_fn_to_src(input logic [15:0] fn);
        dpa_src_type src;
        if (fn == `DPA_FN_UNUSED) begin
            src = DPA_SRC_NONE;
        end else if (fn == `DPA_FN_PLC) begin
            src = DPA_SRC_PLC;
        end else if (fn == `DPA_FN_SERIAL) begin
            src = DPA_SRC_SERIAL;
        end else if (fn >= `DPA_FN_ECHO_FIRST) begin
            src = DPA_SRC_ECHO;
        end else begin
            src = DPA_SRC_INTERNAL;
        end
        return src;
    endfunction

    function automatic dpa_pct_type dpa_sat_pct(input logic [31:0] v);
        return (v > 32'(`DPA_PCT_FULL)) ? `DPA_PCT_FULL : v[15:0];
    endfunction

    function automatic logic [11:0] dpa_clamp_freq(input logic [11:0] f);
        logic [11:0] r;
        r = f;
        if (f < `DPA_FREQ_MIN) begin
            r = `DPA_FREQ_MIN;
        end else if (f > `DPA_FREQ_MAX) begin
            r = `DPA_FREQ_MAX;
        end
        return r;
    endfunction

endpackage

// ### verilog/dpa_pwm_channel.sv
`timescale 1ns/10ps

module dpa_pwm_channel import dpa_pkg::*; (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // shared timebase
    input  wire logic [31:0] phase_i,
    // command and span
    input  wire dpa_pct_type cmd_i,
    input  wire dpa_pct_type min_i,
    input  wire dpa_pct_type max_i,
    // mode
    input  wire logic        pwm_mode_i,
    input  wire logic        active_i,
    input  wire logic        do_i,
    // results
    output logic             oe_o,
    output dpa_pct_type      duty_o,
    output logic             clip_o
);

    dpa_pct_type duty;
    dpa_pct_type next_duty;
    logic        oe;
    logic        next_oe;
    logic        clip;
    logic        next_clip;

    always_comb begin
        logic [15:0] cmd_c;
        logic [15:0] span;
        logic [42:0] prod;
        logic [31:0] scaled;
        logic [31:0] thr;
        logic        level;
        cmd_c = dpa_sat_pct(32'(cmd_i));
        span  = (max_i > min_i) ? (max_i - min_i) : 16'h0000;
        // command mapped into min..max, resolution shrinks with the span
        prod   = 43'(cmd_c) * 43'(span) * 43'(`DPA_RECIP_1000);
        scaled = 32'(min_i) + 32'(prod >> `DPA_RECIP_SHIFT);
        next_duty = dpa_sat_pct(scaled);
        // flags a command above full scale that the clamp had to cut
        next_clip = pwm_mode_i && active_i && (cmd_i > `DPA_PCT_FULL);
        thr   = 32'(duty) * `DPA_THR_PER_STEP;
        // full scale forces a steady high, the phase never reaches 2^32
        level = (duty >= `DPA_PCT_FULL) || (phase_i < thr);
        if (pwm_mode_i) begin
            // open collector: transistor on during the low part
            next_oe = active_i && !level;
        end else begin
            next_oe = do_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            duty <= '0;
            oe   <= 1'h0;
            clip <= 1'h0;
        end else begin
            duty <= next_duty;
            oe   <= next_oe;
            clip <= next_clip;
        end
    end

    assign oe_o   = oe;
    assign duty_o = duty;
    assign clip_o = clip;

endmodule // dpa_pwm_channel

// ### verilog/dpa_top.sv
`timescale 1ns/10ps

// Summary of operation
// - both pulse outputs run at one shared frequency set between 1 Hz and 2500 Hz.
// - each output keeps its own duty value, independent of the other.
// - each output's duty follows the analogue command assigned to it.
// - with the pwm function set, general outputs 11 and 12 become analogue outputs a and b.
// - a plc-driven output takes only the plc value; plc use of another output raises a warning.
// - a serial-driven output takes only values written over the communication ports.
// - echo function codes reproduce a measurement through a conversion curve.
// - minimum and maximum percentages narrow the output span.

module dpa_top import dpa_pkg::*; (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // internal control commands, 0.1 % units
    input  wire dpa_pct_type ctl_cmd_a_i,
    input  wire dpa_pct_type ctl_cmd_b_i,
    // plc commands and use flags
    input  wire dpa_pct_type plc_cmd_a_i,
    input  wire dpa_pct_type plc_cmd_b_i,
    input  wire logic        plc_use_a_i,
    input  wire logic        plc_use_b_i,
    // measurements for echo
    input  wire logic [15:0] meas_a_i,
    input  wire logic [15:0] meas_b_i,
    // plain digital drive when not in pwm mode
    input  wire logic        do_a_i,
    input  wire logic        do_b_i,
    // open-collector pins
    output logic             pwm_analogue_out_a_o,
    output logic             pwm_analogue_out_a_oe_o,
    output logic             pwm_analogue_out_b_o,
    output logic             pwm_analogue_out_b_oe_o,
    // interrupt
    output logic             irq_o
);

    localparam int NCH = 2;

    // control registers
    logic [1:0]               output_as_pwm_function;
    logic [1:0]               next_output_as_pwm_function;
    logic [11:0]              freq;
    logic [11:0]              next_freq;
    logic [15:0]              func        [NCH];
    logic [15:0]              next_func   [NCH];
    dpa_pct_type              pct_min     [NCH];
    dpa_pct_type              next_pct_min[NCH];
    dpa_pct_type              pct_max     [NCH];
    dpa_pct_type              next_pct_max[NCH];
    dpa_pct_type              serial      [NCH];
    dpa_pct_type              next_serial [NCH];
    logic [15:0]              gain        [NCH];
    logic [15:0]              next_gain   [NCH];
    logic [15:0]              offset      [NCH];
    logic [15:0]              next_offset [NCH];
    logic [`DPA_ST_W-1:0]     status;
    logic [`DPA_ST_W-1:0]     next_status;
    logic [`DPA_ST_W-1:0]     mask;
    logic [`DPA_ST_W-1:0]     next_mask;
    logic [31:0]              rdata;
    logic [31:0]              next_rdata;
    logic                     irq;
    logic                     next_irq;
    // timebase
    logic [31:0]              phase;
    logic [31:0]              next_phase;
    // per-output datapath
    dpa_pct_type              cmd      [NCH];
    logic                     active   [NCH];
    logic                     oe       [NCH];
    dpa_pct_type              duty     [NCH];
    logic                     clip     [NCH];
    dpa_pct_type              ctl_cmd  [NCH];
    dpa_pct_type              plc_cmd  [NCH];
    logic                     plc_use  [NCH];
    logic [15:0]              meas     [NCH];
    logic                     do_in    [NCH];
    logic                     pins_oe  [NCH];
    logic                     next_pins_oe[NCH];

    assign ctl_cmd[0] = ctl_cmd_a_i;
    assign ctl_cmd[1] = ctl_cmd_b_i;
    assign plc_cmd[0] = plc_cmd_a_i;
    assign plc_cmd[1] = plc_cmd_b_i;
    assign plc_use[0] = plc_use_a_i;
    assign plc_use[1] = plc_use_b_i;
    assign meas[0]    = meas_a_i;
    assign meas[1]    = meas_b_i;
    assign do_in[0]   = do_a_i;
    assign do_in[1]   = do_b_i;

    function automatic logic [2:0] ch_sel(input int c);
        return (c == 0) ? `DPA_CH_A_SEL : `DPA_CH_B_SEL;
    endfunction

    // one accumulator for both outputs keeps their periods locked together
    always_comb begin
        logic [27:0] prod;
        // 28 bits hold 2500 Hz times the step without overflow
        prod       = 28'(freq) * 28'(`DPA_STEP_PER_HZ);
        next_phase = phase + {14'h0000, prod[27:`DPA_STEP_SHIFT]};
    end

    // source selection
    always_comb begin
        logic [31:0] echo;
        dpa_src_type src;
        echo = '0;
        src  = DPA_SRC_NONE;
        for (int c = 0; c < NCH; c++) begin
            src  = dpa_fn_to_src(func[c]);
            echo = 32'(offset[c]) + ((32'(meas[c]) * 32'(gain[c])) >> `DPA_GAIN_SHIFT);
            active[c] = (src != DPA_SRC_NONE);
            unique case (src)
                DPA_SRC_NONE:   cmd[c] = '0;
                DPA_SRC_PLC:    cmd[c] = plc_cmd[c];
                DPA_SRC_SERIAL: cmd[c] = serial[c];
                DPA_SRC_ECHO:   cmd[c] = dpa_sat_pct(echo);
                default:        cmd[c] = ctl_cmd[c];
            endcase
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        dpa_pwm_channel u_ch (
            .clk_i      (clk_i),
            .reset_i    (reset_i),
            .phase_i    (phase),
            .cmd_i      (cmd[c]),
            .min_i      (pct_min[c]),
            .max_i      (pct_max[c]),
            .pwm_mode_i (output_as_pwm_function[c]),
            .active_i   (active[c]),
            .do_i       (do_in[c]),
            .oe_o       (oe[c]),
            .duty_o     (duty[c]),
            .clip_o     (clip[c])
        );
    end

    // register writes
    always_comb begin
        logic [`DPA_ST_W-1:0] ev;
        logic [`DPA_ST_W-1:0] clr;
        logic                 hit;
        hit = 1'b0;
        ev  = '0;
        next_output_as_pwm_function = output_as_pwm_function;
        next_freq = freq;
        next_mask = mask;
        clr       = '0;
        for (int c = 0; c < NCH; c++) begin
            next_func[c]    = func[c];
            next_pct_min[c] = pct_min[c];
            next_pct_max[c] = pct_max[c];
            next_serial[c]  = serial[c];
            next_gain[c]    = gain[c];
            next_offset[c]  = offset[c];
        end
        if (wr_i) begin
            if (addr_i == `DPA_ADDR_CTRL) begin
                next_output_as_pwm_function = wdata_i[1:0];
            end
            if (addr_i == `DPA_ADDR_FREQ) begin
                next_freq = dpa_clamp_freq(wdata_i[11:0]);
            end
            if (addr_i == `DPA_ADDR_MASK) begin
                next_mask = wdata_i[`DPA_ST_W-1:0];
            end
            if (addr_i == `DPA_ADDR_STATUS) begin
                clr = wdata_i[`DPA_ST_W-1:0];
            end
            for (int c = 0; c < NCH; c++) begin
                // analogue settings exist only while the output is in pwm mode
                hit = (addr_i[7:5] == ch_sel(c)) && output_as_pwm_function[c];
                if (hit && addr_i[4:0] == `DPA_OFS_FUNC) begin
                    next_func[c] = wdata_i[15:0];
                end
                if (hit && addr_i[4:0] == `DPA_OFS_MIN) begin
                    next_pct_min[c] = dpa_sat_pct(32'(wdata_i[15:0]));
                end
                if (hit && addr_i[4:0] == `DPA_OFS_MAX) begin
                    next_pct_max[c] = dpa_sat_pct(32'(wdata_i[15:0]));
                end
                if (hit && addr_i[4:0] == `DPA_OFS_SERIAL) begin
                    next_serial[c] = wdata_i[15:0];
                end
                if (hit && addr_i[4:0] == `DPA_OFS_CURVE) begin
                    next_gain[c]   = wdata_i[31:16];
                    next_offset[c] = wdata_i[15:0];
                end
            end
        end
        // a plc that drives an output not handed to it gets nothing but a warning
        ev[`DPA_ST_PLC_A]  = plc_use[0] && (dpa_fn_to_src(func[0]) != DPA_SRC_PLC);
        ev[`DPA_ST_PLC_B]  = plc_use[1] && (dpa_fn_to_src(func[1]) != DPA_SRC_PLC);
        ev[`DPA_ST_CLIP_A] = clip[0];
        ev[`DPA_ST_CLIP_B] = clip[1];
        // set wins over a write-one clear in the same cycle
        next_status = (status & ~clr) | ev;
        next_irq    = |(next_status & next_mask);
    end

    // read path, data valid the cycle after the strobe only
    always_comb begin
        logic sel;
        sel        = 1'b0;
        next_rdata = '0;
        if (rd_i) begin
            unique case (addr_i)
                `DPA_ADDR_CTRL:   next_rdata = {30'h0000_0000, output_as_pwm_function};
                `DPA_ADDR_FREQ:   next_rdata = {20'h0_0000, freq};
                `DPA_ADDR_STATUS: next_rdata = {28'h000_0000, status};
                `DPA_ADDR_MASK:   next_rdata = {28'h000_0000, mask};
                default:          next_rdata = '0;
            endcase
            for (int c = 0; c < NCH; c++) begin
                // a block outside pwm mode reads zero, as unmapped space does
                sel = (addr_i[7:5] == ch_sel(c)) && output_as_pwm_function[c];
                if (sel) begin
                    unique case (addr_i[4:0])
                        `DPA_OFS_FUNC:   next_rdata = {16'h0000, func[c]};
                        `DPA_OFS_MIN:    next_rdata = {16'h0000, pct_min[c]};
                        `DPA_OFS_MAX:    next_rdata = {16'h0000, pct_max[c]};
                        `DPA_OFS_SERIAL: next_rdata = {16'h0000, serial[c]};
                        `DPA_OFS_CURVE:  next_rdata = {gain[c], offset[c]};
                        `DPA_OFS_DUTY:   next_rdata = {16'h0000, duty[c]};
                        default:         next_rdata = '0;
                    endcase
                end
            end
        end
        for (int c = 0; c < NCH; c++) begin
            next_pins_oe[c] = oe[c];
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            output_as_pwm_function <= '0;
            freq    <= `DPA_FREQ_RST;
            status  <= '0;
            mask    <= '0;
            rdata   <= '0;
            irq     <= 1'h0;
            phase   <= '0;
            for (int c = 0; c < NCH; c++) begin
                func[c]    <= `DPA_FN_UNUSED;
                pct_min[c] <= `DPA_PCT_RST_MIN;
                pct_max[c] <= `DPA_PCT_RST_MAX;
                serial[c]  <= '0;
                gain[c]    <= `DPA_GAIN_RST;
                offset[c]  <= '0;
                pins_oe[c] <= 1'h0;
            end
        end else begin
            output_as_pwm_function <= next_output_as_pwm_function;
            freq    <= next_freq;
            status  <= next_status;
            mask    <= next_mask;
            rdata   <= next_rdata;
            irq     <= next_irq;
            phase   <= next_phase;
            for (int c = 0; c < NCH; c++) begin
                func[c]    <= next_func[c];
                pct_min[c] <= next_pct_min[c];
                pct_max[c] <= next_pct_max[c];
                serial[c]  <= next_serial[c];
                gain[c]    <= next_gain[c];
                offset[c]  <= next_offset[c];
                pins_oe[c] <= next_pins_oe[c];
            end
        end
    end

    // open collector only ever pulls low
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pwm_analogue_out_a_o <= 1'h0;
            pwm_analogue_out_b_o <= 1'h0;
        end else begin
            pwm_analogue_out_a_o <= 1'h0;
            pwm_analogue_out_b_o <= 1'h0;
        end
    end

    assign pwm_analogue_out_a_oe_o = pins_oe[0];
    assign pwm_analogue_out_b_oe_o = pins_oe[1];
    assign rdata_o = rdata;
    assign irq_o   = irq;

endmodule // dpa_top

// ### sim/dpa_top_properties.sv
`timescale 1ns/10ps
`include "dpa_defines.svh"

module dpa_top_properties (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        reset_i,
    // register port
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    // pins and interrupt
    input wire logic        do_a_i,
    input wire logic        pwm_analogue_out_a_o,
    input wire logic        pwm_analogue_out_a_oe_o,
    input wire logic        pwm_analogue_out_b_o,
    input wire logic        pwm_analogue_out_b_oe_o,
    input wire logic        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == '0)
        else $error("read data not zero outside its slot");
    a_unmapped_zero: assert property (rd_i && addr_i == 8'h10 |=> rdata_o == '0)
        else $error("unmapped read not zero");
    a_freq_range: assert property (rd_i && addr_i == `DPA_ADDR_FREQ
        |=> rdata_o inside {[1:2500]}) else $error("frequency out of range");
    a_duty_clamped: assert property (rd_i && addr_i == 8'h34
        |=> rdata_o[31:16] == '0 && rdata_o[15:0] <= `DPA_PCT_FULL)
        else $error("duty above full scale");
    a_status_narrow: assert property (rd_i && addr_i == `DPA_ADDR_STATUS
        |=> rdata_o[31:4] == '0) else $error("status upper bits set");
    a_pins_open: assert property (!pwm_analogue_out_a_o && !pwm_analogue_out_b_o)
        else $error("open collector pin driven high");
    // the interrupt flop takes the new mask on the same edge that loads the mask register
    a_mask_quiet: assert property (wr_i && addr_i == `DPA_ADDR_MASK && wdata_i[3:0] == 4'h0
        ##1 !wr_i |=> !irq_o) else $error("interrupt high with mask cleared");
    a_do_follow: assert property (wr_i && addr_i == `DPA_ADDR_CTRL && !wdata_i[0]
        ##1 (!wr_i && $stable(do_a_i)) [*3] |-> pwm_analogue_out_a_oe_o == do_a_i)
        else $error("pin does not follow digital request");

    c_duty_read: cover property (rd_i && addr_i == 8'h34);
    c_irq_up: cover property ($rose(irq_o));
    c_period_start: cover property ($fell(pwm_analogue_out_a_oe_o));
endmodule // dpa_top_properties

// ### sim/dpa_pwm_sink.sv
`timescale 1ns/10ps

module dpa_pwm_sink (
    // clock
    input  wire logic clk_i,
    // transistor on when high
    input  wire logic oe_i,
    // last full period, in cycles
    output int        period_o,
    output int        high_o,
    output int        periods_o
);
    // actuator input has a pull-up, so a released line reads high
    logic line;
    logic line_q = 1'b1;
    int   cnt    = 0;
    int   hcnt   = 0;

    assign line = !oe_i;

    initial begin
        period_o = 0;
        high_o = 0;
        periods_o = 0;
    end

    // period measured rise to rise, as a governor input does
    always @(posedge clk_i) begin
        line_q <= line;
        if (line && !line_q) begin
            period_o <= cnt;
            high_o <= hcnt;
            periods_o <= periods_o + 1;
            cnt <= 1;
            hcnt <= 1;
        end else begin
            cnt <= cnt + 1;
            hcnt <= hcnt + int'(line);
        end
    end
endmodule // dpa_pwm_sink

// ### sim/dpa_top_tb.sv
`timescale 1ns/10ps

module dpa_top_tb import dpa_pkg::*;;
    logic        clk_i       = 1'b0;
    logic        reset_i     = 1'b1;
    logic [7:0]  addr_i      = 8'h00;
    logic [31:0] wdata_i     = '0;
    logic        wr_i        = 1'b0;
    logic        rd_i        = 1'b0;
    logic [31:0] rdata_o;
    dpa_pct_type ctl_cmd_a_i = '0;
    dpa_pct_type ctl_cmd_b_i = '0;
    dpa_pct_type plc_cmd_a_i = '0;
    logic        plc_use_a_i = 1'b0;
    logic        plc_use_b_i = 1'b0;
    logic [15:0] meas_a_i    = '0;
    logic        do_a_i      = 1'b0;
    logic        out_a;
    logic        oe_a;
    logic        out_b;
    logic        oe_b;
    logic        irq_o;
    int          errors      = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    int          per_a, hi_a, n_a, per_b, hi_b, n_b;

    always #5 clk_i = ~clk_i;

    dpa_top i_dpa_top (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ctl_cmd_a_i(ctl_cmd_a_i),
        .ctl_cmd_b_i(ctl_cmd_b_i), .plc_cmd_a_i(plc_cmd_a_i), .plc_cmd_b_i(16'h0000),
        .plc_use_a_i(plc_use_a_i), .plc_use_b_i(plc_use_b_i), .meas_a_i(meas_a_i),
        .meas_b_i(16'h0000), .do_a_i(do_a_i), .do_b_i(1'b0), .pwm_analogue_out_a_o(out_a),
        .pwm_analogue_out_a_oe_o(oe_a), .pwm_analogue_out_b_o(out_b),
        .pwm_analogue_out_b_oe_o(oe_b), .irq_o(irq_o));
    dpa_pwm_sink i_dpa_pwm_sink (.clk_i(clk_i), .oe_i(oe_a), .period_o(per_a),
        .high_o(hi_a), .periods_o(n_a));
    dpa_pwm_sink i_dpa_pwm_sink_b (.clk_i(clk_i), .oe_i(oe_b), .period_o(per_b),
        .high_o(hi_b), .periods_o(n_b));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // longest test waits two full periods at 2500 Hz
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            $display("BAD timeout expected finish seen hang");
            errors++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic near(input string what, input int exp, input int got);
        checks_done++;
        if (got < exp - 2 || got > exp + 2) begin
            errors++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check(what, exp, rdata_o);
        @(posedge clk_i);
    endtask

    function automatic logic [31:0] duty(input int mn, input int mx, input int cmd);
        int c;
        int d;
        c = (cmd > 1000) ? 1000 : cmd;
        d = (mx <= mn) ? mn : mn + ((c * (mx - mn) * 1049) >>> 20);
        return 32'((d > 1000) ? 1000 : d);
    endfunction

    task automatic t_reset();
        rd_chk(8'h00, 32'h0, "ctrl");
        rd_chk(8'h04, 32'h1F4, "freq");
        rd_chk(8'h0C, 32'h0, "mask");
        rd_chk(8'h10, 32'h0, "unmapped");
        rd_chk(8'h20, 32'h0, "hidden func");
        $display("test reset done");
    endtask

    task automatic t_freq();
        wr(8'h04, 32'h0);
        rd_chk(8'h04, 32'h1, "freq low");
        wr(8'h04, 32'hBB8);
        rd_chk(8'h04, 32'h9C4, "freq high");
        wr(8'h04, 32'h9C4);
        rd_chk(8'h04, 32'h9C4, "freq max");
        $display("test frequency done");
    endtask

    task automatic t_mode();
        int step;
        int n0;
        int i;
        wr(8'h20, 32'h1000);
        wr(8'h00, 32'h3);
        rd_chk(8'h20, 32'h0, "write while hidden");
        wr(8'h20, 32'h1000);
        wr(8'h40, 32'h102);
        wr(8'h4C, 32'hFA);
        ctl_cmd_a_i <= 16'h1F4;
        ctl_cmd_b_i <= 16'h384;
        tick(4);
        rd_chk(8'h34, duty(0, 1000, 500), "duty a");
        rd_chk(8'h54, duty(0, 1000, 250), "duty b serial");
        ctl_cmd_a_i <= 16'h2EE;
        tick(4);
        rd_chk(8'h34, duty(0, 1000, 750), "duty a new");
        rd_chk(8'h54, duty(0, 1000, 250), "duty b kept");
        n0 = n_a;
        for (i = 0; i < 100000 && (n_a < n0 + 2 || n_b < n0 + 2); i++) begin
            @(posedge clk_i);
        end
        step = (2500 * 43980) >>> 10;
        near("period a", int'(64'h1_0000_0000 / step), per_a);
        near("period b", per_a, per_b);
        near("high a", int'(64'd750 * 4294967 / step), hi_a);
        near("high b", int'(64'd250 * 4294967 / step), hi_b);
        $display("test pwm mode done");
    endtask

    task automatic t_span();
        ctl_cmd_a_i <= 16'h1F4;
        wr(8'h24, 32'hC8);
        wr(8'h28, 32'h258);
        tick(3);
        rd_chk(8'h34, duty(200, 600, 500), "span duty");
        ctl_cmd_a_i <= 16'h4B0;
        tick(3);
        rd_chk(8'h34, duty(200, 600, 1200), "span top");
        rd_chk(8'h08, 32'h4, "clip a");
        wr(8'h24, 32'h5DC);
        rd_chk(8'h24, 32'h3E8, "min clamp");
        tick(2);
        rd_chk(8'h34, duty(1000, 600, 1200), "empty span");
        wr(8'h24, 32'h0);
        wr(8'h28, 32'h3E8);
        $display("test span done");
    endtask

    task automatic t_plc();
        wr(8'h20, 32'h101);
        wr(8'h08, 32'hF);
        plc_cmd_a_i <= 16'h12C;
        ctl_cmd_a_i <= 16'h384;
        tick(3);
        rd_chk(8'h34, duty(0, 1000, 300), "plc duty");
        wr(8'h0C, 32'h3);
        plc_use_a_i <= 1'b1;
        plc_use_b_i <= 1'b1;
        tick(3);
        plc_use_a_i <= 1'b0;
        plc_use_b_i <= 1'b0;
        tick(2);
        rd_chk(8'h08, 32'h2, "plc warning");
        rd_chk(8'h54, duty(0, 1000, 250), "b kept");
        check("irq set", 1'b1, irq_o);
        wr(8'h08, 32'h2);
        tick(2);
        rd_chk(8'h08, 32'h0, "warning cleared");
        check("irq clear", 1'b0, irq_o);
        wr(8'h0C, 32'h0);
        $display("test plc done");
    endtask

    task automatic t_echo();
        logic [15:0] codes [2] = '{16'h3001, 16'h3100};
        foreach (codes[k]) begin
            wr(8'h20, 32'(codes[k]));
            wr(8'h30, 32'h0200_0010);
            meas_a_i <= 16'h64;
            tick(4);
            rd_chk(8'h34, duty(0, 1000, 216), "echo duty");
            meas_a_i <= 16'h258;
            tick(4);
            rd_chk(8'h34, duty(0, 1000, 1216), "echo clamp");
        end
        $display("test echo done");
    endtask

    task automatic t_pins();
        wr(8'h20, 32'h102);
        wr(8'h20, 32'h0);
        tick(3);
        check("unused released", 1'b0, oe_a);
        do_a_i <= 1'b1;
        wr(8'h00, 32'h0);
        tick(5);
        check("digital on", 1'b1, oe_a);
        do_a_i <= 1'b0;
        tick(5);
        check("digital off", 1'b0, oe_a);
        rd_chk(8'h34, 32'h0, "hidden duty");
        $display("test pins done");
    endtask

    initial begin
        tick(3);
        reset_i <= 1'b0;
        t_reset();
        t_freq();
        t_mode();
        t_span();
        t_plc();
        t_echo();
        t_pins();
        tally_and_finish();
    end
endmodule // dpa_top_tb

bind dpa_top dpa_top_properties i_dpa_top_properties (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .do_a_i(do_a_i), .pwm_analogue_out_a_o(pwm_analogue_out_a_o),
    .pwm_analogue_out_a_oe_o(pwm_analogue_out_a_oe_o),
    .pwm_analogue_out_b_o(pwm_analogue_out_b_o),
    .pwm_analogue_out_b_oe_o(pwm_analogue_out_b_oe_o), .irq_o(irq_o));
